// >>> byte_fifo.sv
// package of shared constants and the parameterised byte fifo
`timescale 1ns/1ns

package radio_fifo_pkg;
  // fifo geometry
  localparam int          BYTE_W        = 8;
  localparam int          FIFO_DEPTH    = 64;
  localparam int          CNT_W         = 7;
  localparam logic [6:0]  CNT_ZERO      = 7'h00;
  localparam logic [6:0]  CNT_ONE       = 7'h01;
  localparam logic [6:0]  DEMOD_STOP    = 7'h3f;
  // watermark coding: rx = base + 4v, tx = base - 4v
  localparam logic [6:0]  RX_THR_BASE   = 7'h04;
  localparam logic [6:0]  TX_THR_BASE   = 7'h3d;
  // output pin source codes
  localparam logic [5:0]  PIN_SEL_RX    = 6'h00;
  localparam logic [5:0]  PIN_SEL_TX    = 6'h02;
  // serial framing
  localparam logic [2:0]  BIT_FIRST     = 3'h0;
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam logic [2:0]  SYNC_IDLE_HI  = 3'h7;
  // serial access phases
  typedef enum logic [1:0] {PH_IDLE, PH_HEADER, PH_DATA} spi_phase_e;
endpackage : radio_fifo_pkg

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in,
  output logic [AW:0]           count_out
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_state_s;

  fifo_state_s st_ff;
  fifo_state_s nxt_st;
  logic        push;
  logic        pop;

  // pointer and count update, refuses writes when full and reads when empty
  always_comb begin
    nxt_st = st_ff;
    push   = in_valid_in && (st_ff.cnt != (AW+1)'(DEPTH));
    pop    = out_ready_in && (st_ff.cnt != '0);
    if (push) begin
      nxt_st.mem[st_ff.wr] = in_data_in;
      nxt_st.wr            = st_ff.wr + AW'(1);
    end
    if (pop) begin
      nxt_st.rd = st_ff.rd + AW'(1);
    end
    if (push && !pop) begin
      nxt_st.cnt = st_ff.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      nxt_st.cnt = st_ff.cnt - (AW+1)'(1);
    end
    if (!resetn_in) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    st_ff <= nxt_st;
  end

  // handshake and peek outputs
  assign in_ready_out  = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (st_ff.cnt != '0);
  assign out_data_out  = st_ff.mem[st_ff.rd];
  assign count_out     = st_ff.cnt;

endmodule : byte_fifo

// >>> fifo_port_checker.sv
// port-level assertions for the receive and transmit byte fifos
`timescale 1ns/1ns
module fifo_port_checker (
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic       csn_in,
  input wire logic       so_out,
  input wire logic       demod_valid_in,
  input wire logic       demod_ready_out,
  input wire logic       mod_valid_out,
  input wire logic [7:0] mod_data_out,
  input wire logic       mod_ready_in,
  input wire logic [3:0] buffer_watermark_select_in,
  input wire logic [5:0] output_pin_select_in,
  input wire logic       error_clear_in,
  input wire logic [6:0] receive_fill_count_out,
  input wire logic [6:0] transmit_fill_count_out,
  input wire logic       rx_overflow_out,
  input wire logic       tx_underflow_out,
  input wire logic       general_output_pin_out
);
  logic [6:0] rx_thr;
  logic [6:0] tx_thr;
  // watermark levels from the code
  assign rx_thr = radio_fifo_pkg::RX_THR_BASE + {1'b0, buffer_watermark_select_in, 2'b00};
  assign tx_thr = radio_fifo_pkg::TX_THR_BASE - {1'b0, buffer_watermark_select_in, 2'b00};
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  // serial port quiet, configuration unchanged
  sequence s_quiet; csn_in [*5]; endsequence
  sequence s_cfg; $stable(buffer_watermark_select_in) && $stable(output_pin_select_in); endsequence
  property p_reset; $rose(resetn_in) |-> receive_fill_count_out == 7'h00 &&
    transmit_fill_count_out == 7'h00 && !rx_overflow_out && !tx_underflow_out; endproperty
  a_reset: assert property (p_reset) else $error("state not clear after reset");
  property p_ovf; s_quiet ##0 (demod_valid_in && receive_fill_count_out == 7'h40 &&
    !error_clear_in) |=> rx_overflow_out; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");
  property p_ovf_hold; rx_overflow_out && !error_clear_in |=> rx_overflow_out; endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");
  property p_clear; error_clear_in && !demod_valid_in && !mod_ready_in
    |=> !rx_overflow_out && !tx_underflow_out; endproperty
  a_clear: assert property (p_clear) else $error("error flags not cleared");
  property p_udf; mod_ready_in && !mod_valid_out |=> tx_underflow_out; endproperty
  a_udf: assert property (p_udf) else $error("underflow not flagged");
  property p_mod_hold; mod_valid_out && !mod_ready_in |=> mod_valid_out && $stable(mod_data_out);
  endproperty
  a_mod_hold: assert property (p_mod_hold) else $error("modulator byte dropped");
  property p_full; receive_fill_count_out == 7'h40 |-> !demod_ready_out; endproperty
  a_full: assert property (p_full) else $error("ready while receive fifo full");
  property p_pin_rx; s_cfg ##0 output_pin_select_in == radio_fifo_pkg::PIN_SEL_RX
    |-> general_output_pin_out == (receive_fill_count_out >= rx_thr); endproperty
  a_pin_rx: assert property (p_pin_rx) else $error("receive threshold pin wrong");
  property p_pin_tx; s_cfg ##0 output_pin_select_in == radio_fifo_pkg::PIN_SEL_TX
    |-> general_output_pin_out == (transmit_fill_count_out >= tx_thr); endproperty
  a_pin_tx: assert property (p_pin_tx) else $error("transmit threshold pin wrong");
  property p_so_idle; s_quiet |-> !so_out; endproperty
  a_so_idle: assert property (p_so_idle) else $error("serial out busy while idle");
endmodule : fifo_port_checker
bind radio_tx_rx_byte_fifos fifo_port_checker chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .csn_in(csn_in), .so_out(so_out), .demod_valid_in(demod_valid_in),
  .demod_ready_out(demod_ready_out), .mod_valid_out(mod_valid_out),
  .mod_data_out(mod_data_out), .mod_ready_in(mod_ready_in),
  .buffer_watermark_select_in(buffer_watermark_select_in),
  .output_pin_select_in(output_pin_select_in), .error_clear_in(error_clear_in),
  .receive_fill_count_out(receive_fill_count_out),
  .transmit_fill_count_out(transmit_fill_count_out), .rx_overflow_out(rx_overflow_out),
  .tx_underflow_out(tx_underflow_out), .general_output_pin_out(general_output_pin_out));

// >>> radio_tx_rx_byte_fifos.sv
// receive and transmit byte fifos with serial host access and watermark pin
//
// Notes on behaviour
// - two separate 64-byte fifos, one for receive and one for transmit.
// - host reads receive bytes and writes transmit bytes only over serial port.
// - flag receive overflow and transmit underflow.
// - status byte during header carries rx fill on read, tx fill on write.
// - both fill counts are visible as read-only status outputs.
// - demod write during read of last byte keeps pointer; byte repeats.
// - 4-bit code v gives rx threshold 4(v+1) and tx threshold 61-4v.
// - threshold signal high while fill count is at or above threshold.
// - output pin select 0x00 shows rx threshold, 0x02 tx threshold.
`timescale 1ns/1ns

module radio_tx_rx_byte_fifos (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // serial host port, asynchronous pins
  input  wire logic       sclk_in,
  input  wire logic       csn_in,
  input  wire logic       si_in,
  output logic            so_out,
  // demodulator side
  input  wire logic       demod_valid_in,
  input  wire logic [7:0] demod_data_in,
  output logic            demod_ready_out,
  // modulator side
  output logic            mod_valid_out,
  output logic [7:0]      mod_data_out,
  input  wire logic       mod_ready_in,
  // configuration
  input  wire logic [3:0] buffer_watermark_select_in,
  input  wire logic [5:0] output_pin_select_in,
  input  wire logic       error_clear_in,
  // status
  output logic [6:0]      receive_fill_count_out,
  output logic [6:0]      transmit_fill_count_out,
  output logic            rx_overflow_out,
  output logic            tx_underflow_out,
  output logic            general_output_pin_out
);

  typedef struct packed {
    logic [2:0]                  sclk_s;
    logic [2:0]                  csn_s;
    logic [1:0]                  si_s;
    radio_fifo_pkg::spi_phase_e  phase;
    logic                        is_read;
    logic                        rd_pend;
    logic [2:0]                  bit_cnt;
    logic [7:0]                  shift_in;
    logic [7:0]                  shift_out;
    logic                        so;
    logic [7:0]                  mod_data;
    logic                        mod_valid;
    logic                        demod_ready;
    logic                        rx_ovf;
    logic                        tx_unf;
    logic                        pin;
    logic [6:0]                  rx_stat;
    logic [6:0]                  tx_stat;
  } top_state_s;

  top_state_s st_ff;
  top_state_s nxt_st;

  // fifo handshakes
  logic       rx_in_ready;
  logic       rx_out_valid;
  logic [7:0] rx_out_data;
  logic [6:0] rx_count;
  logic       rx_pop;
  logic       tx_in_ready;
  logic       tx_out_valid;
  logic [7:0] tx_out_data;
  logic [6:0] tx_count;
  logic       tx_push;
  logic [7:0] tx_push_data;
  logic       tx_pop;

  // threshold compare, used for both fifos
  function automatic logic level_reached(input logic [6:0] count,
                                         input logic [6:0] thr);
    level_reached = (count >= thr);
  endfunction : level_reached

  // receive fifo, filled by the demodulator, drained by host reads
  byte_fifo #(
    .WIDTH (radio_fifo_pkg::BYTE_W),
    .DEPTH (radio_fifo_pkg::FIFO_DEPTH)
  ) rx_fifo_i (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (demod_valid_in),
    .in_data_in    (demod_data_in),
    .in_ready_out  (rx_in_ready),
    .out_valid_out (rx_out_valid),
    .out_data_out  (rx_out_data),
    .out_ready_in  (rx_pop),
    .count_out     (rx_count)
  );

  // transmit fifo, filled by host writes, drained by the modulator
  byte_fifo #(
    .WIDTH (radio_fifo_pkg::BYTE_W),
    .DEPTH (radio_fifo_pkg::FIFO_DEPTH)
  ) tx_fifo_i (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (tx_push),
    .in_data_in    (tx_push_data),
    .in_ready_out  (tx_in_ready),
    .out_valid_out (tx_out_valid),
    .out_data_out  (tx_out_data),
    .out_ready_in  (tx_pop),
    .count_out     (tx_count)
  );

  // next-state logic for serial port, modulator stage, flags and pin
  always_comb begin
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_active;
    logic       cs_fall;
    logic       rx_push_now;
    logic       rx_thr_hit;
    logic       tx_thr_hit;
    logic [6:0] rx_thr;
    logic [6:0] tx_thr;
    logic [6:0] wm_x4;
    sclk_rise    = st_ff.sclk_s[1] && !st_ff.sclk_s[2];
    sclk_fall    = !st_ff.sclk_s[1] && st_ff.sclk_s[2];
    cs_active    = !st_ff.csn_s[1];
    cs_fall      = !st_ff.csn_s[1] && st_ff.csn_s[2];
    rx_push_now  = demod_valid_in && rx_in_ready;
    wm_x4        = {1'b0, buffer_watermark_select_in, 2'b00};
    rx_thr       = radio_fifo_pkg::RX_THR_BASE + wm_x4;
    tx_thr       = radio_fifo_pkg::TX_THR_BASE - wm_x4;
    rx_thr_hit   = level_reached(rx_count, rx_thr);
    tx_thr_hit   = level_reached(tx_count, tx_thr);
    nxt_st       = st_ff;
    rx_pop       = 1'b0;
    tx_push      = 1'b0;
    tx_push_data = st_ff.shift_in;
    tx_pop       = 1'b0;

    // two-stage synchronisers, third stage only for edge history
    nxt_st.sclk_s = {st_ff.sclk_s[1:0], sclk_in};
    nxt_st.csn_s  = {st_ff.csn_s[1:0], csn_in};
    nxt_st.si_s   = {st_ff.si_s[0], si_in};

    // serial framing: sample on rising sclk, shift out on falling sclk
    if (!cs_active) begin
      nxt_st.phase = radio_fifo_pkg::PH_IDLE;
      nxt_st.so    = 1'b0;
    end else if (cs_fall) begin
      nxt_st.phase     = radio_fifo_pkg::PH_HEADER;
      nxt_st.bit_cnt   = radio_fifo_pkg::BIT_FIRST;
      nxt_st.shift_out = 8'h00;
      nxt_st.so        = 1'b0;
      nxt_st.rd_pend   = 1'b0;
    end else begin
      if (sclk_rise && st_ff.phase != radio_fifo_pkg::PH_IDLE) begin
        nxt_st.shift_in = {st_ff.shift_in[6:0], st_ff.si_s[1]};
        nxt_st.bit_cnt  = st_ff.bit_cnt + 3'h1;
        // loaded byte leaves the fifo only once the host clocks its first bit,
        // so a prefetch at the end of an access never loses a byte
        if (st_ff.phase == radio_fifo_pkg::PH_DATA && st_ff.is_read &&
            st_ff.bit_cnt == radio_fifo_pkg::BIT_FIRST) begin
          nxt_st.rd_pend = 1'b0;
          // pointer held when the last byte collides with a new arrival
          rx_pop = st_ff.rd_pend &&
                   !(rx_count == radio_fifo_pkg::CNT_ONE && rx_push_now);
        end
        // first header bit picks direction and the fill count to report
        if (st_ff.phase == radio_fifo_pkg::PH_HEADER &&
            st_ff.bit_cnt == radio_fifo_pkg::BIT_FIRST) begin
          nxt_st.is_read   = st_ff.si_s[1];
          nxt_st.shift_out = st_ff.si_s[1] ? {rx_count, 1'b0}
                                           : {tx_count, 1'b0};
        end
        // byte boundary
        if (st_ff.bit_cnt == radio_fifo_pkg::BIT_LAST) begin
          nxt_st.phase = radio_fifo_pkg::PH_DATA;
          if (st_ff.phase == radio_fifo_pkg::PH_DATA && !st_ff.is_read) begin
            // a byte written while full is dropped by the fifo
            tx_push      = 1'b1;
            tx_push_data = {st_ff.shift_in[6:0], st_ff.si_s[1]};
          end
          if (st_ff.is_read) begin
            // stale data is loaded when empty and then never popped
            nxt_st.shift_out = rx_out_data;
            nxt_st.rd_pend   = rx_out_valid;
          end
        end
      end
      if (sclk_fall) begin
        nxt_st.so        = st_ff.shift_out[7];
        nxt_st.shift_out = {st_ff.shift_out[6:0], 1'b0};
      end
    end

    // modulator output register, refilled from the transmit fifo
    if (!st_ff.mod_valid || mod_ready_in) begin
      tx_pop           = 1'b1;
      nxt_st.mod_valid = tx_out_valid;
      if (tx_out_valid) begin
        nxt_st.mod_data = tx_out_data;
      end
    end

    // demodulator may push while the receive count is below 63, two or more below full
    nxt_st.demod_ready = (rx_count < radio_fifo_pkg::DEMOD_STOP);

    // sticky error flags, an event beats a same-cycle clear
    if (error_clear_in) begin
      nxt_st.rx_ovf = 1'b0;
      nxt_st.tx_unf = 1'b0;
    end
    if (demod_valid_in && !rx_in_ready) begin
      nxt_st.rx_ovf = 1'b1;
    end
    if (mod_ready_in && !st_ff.mod_valid) begin
      nxt_st.tx_unf = 1'b1;
    end

    // fill counts for status
    nxt_st.rx_stat = rx_count;
    nxt_st.tx_stat = tx_count;

    // threshold indication onto the general output pin
    if (output_pin_select_in == radio_fifo_pkg::PIN_SEL_RX) begin
      nxt_st.pin = rx_thr_hit;
    end else if (output_pin_select_in == radio_fifo_pkg::PIN_SEL_TX) begin
      nxt_st.pin = tx_thr_hit;
    end else begin
      nxt_st.pin = 1'b0;
    end

    // synchronous reset, select lines idle high
    if (!resetn_in) begin
      nxt_st        = '0;
      nxt_st.csn_s  = radio_fifo_pkg::SYNC_IDLE_HI;
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    st_ff <= nxt_st;
  end

  // outputs straight from the state register
  assign so_out                  = st_ff.so;
  assign demod_ready_out         = st_ff.demod_ready;
  assign mod_valid_out           = st_ff.mod_valid;
  assign mod_data_out            = st_ff.mod_data;
  assign receive_fill_count_out  = st_ff.rx_stat;
  assign transmit_fill_count_out = st_ff.tx_stat;
  assign rx_overflow_out         = st_ff.rx_ovf;
  assign tx_underflow_out        = st_ff.tx_unf;
  assign general_output_pin_out  = st_ff.pin;

endmodule : radio_tx_rx_byte_fifos

// >>> spi_host_model.sv
// host side of the serial port, mode 0, msb first
`timescale 1ns/1ns
module spi_host_model (
  output logic      sclk_out,
  output logic      csn_out,
  output logic      si_out,
  input  wire logic so_in
);
  // idle: deselected, clock low
  initial begin
    sclk_out = 1'b0;
    csn_out  = 1'b1;
    si_out   = 1'b0;
  end
  // select, then allow setup before first rise
  task automatic start;
    csn_out = 1'b0;
    #160;
  endtask : start
  // one byte each way; so sampled late in the high phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_out = tx[i];
      #80 sclk_out = 1'b1;
      #79 rx[i] = so_in;
      #1 sclk_out = 1'b0;
    end
  endtask : xfer
  // deselect; data line carries nothing now
  task automatic stop;
    #160 csn_out = 1'b1;
    si_out = ~si_out;
    #320;
  endtask : stop
endmodule : spi_host_model

// >>> tb.sv
// self-checking bench for the receive and transmit byte fifos
`timescale 1ns/1ns
module tb;
  logic       clk_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic       dv = 1'b0, mr = 1'b0, eclr = 1'b0;
  logic [7:0] dd = 8'h00;
  logic [3:0] wm = 4'h0;
  logic [5:0] psel = 6'h00;
  logic       sclk, csn, si, so, drdy, mv, ovf, udf, pin;
  logic [7:0] md, b, t, u;
  int         left, n0, n1, c;
  logic [6:0] rxc, txc;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  int         n_fail = 0;
  int         num_checks = 0;
  integer     seed = 32'hc4e2;
  // clock and units
  always #10 clk_in = ~clk_in;
  spi_host_model host (.sclk_out(sclk), .csn_out(csn), .si_out(si), .so_in(so));
  radio_tx_rx_byte_fifos uut (.clk_in(clk_in), .resetn_in(resetn_in), .sclk_in(sclk),
    .csn_in(csn), .si_in(si), .so_out(so), .demod_valid_in(dv), .demod_data_in(dd),
    .demod_ready_out(drdy), .mod_valid_out(mv), .mod_data_out(md), .mod_ready_in(mr),
    .buffer_watermark_select_in(wm), .output_pin_select_in(psel), .error_clear_in(eclr),
    .receive_fill_count_out(rxc), .transmit_fill_count_out(txc), .rx_overflow_out(ovf),
    .tx_underflow_out(udf), .general_output_pin_out(pin));
  // step to just after the next rising edge
  task automatic tick;
    @(posedge clk_in);
    #2;
  endtask : tick
  // compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // watchdog
  initial begin
    #1000000;
    n_fail++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (8) tick();
    resetn_in = 1'b1;
    repeat (6) tick();
    chk("rx count", {1'b0, rxc}, 8'h00);
    chk("tx count", {1'b0, txc}, 8'h00);
    for (int k = 1; k <= 65; k++) begin
      chk("demod ready", {7'h00, drdy}, {7'h00, k < 64});
      t = 8'($random(seed));
      if (k < 65) rxq.push_back(t);
      dd = t;
      dv = 1'b1;
      wm = k[3:0];
      tick();
      dv = 1'b0;
      repeat (5) tick();
      chk("rx count", {1'b0, rxc}, 8'(k > 64 ? 64 : k));
      chk("rx pin", {7'h00, pin}, {7'h00, (k > 64 ? 64 : k) >= 4 * (k % 16) + 4});
    end
    chk("overflow", {7'h00, ovf}, 8'h01);
    eclr = 1'b1;
    tick();
    eclr = 1'b0;
    repeat (2) tick();
    chk("overflow", {7'h00, ovf}, 8'h00);
    $display("receive fill done");
    host.start();
    host.xfer(8'h80, b);
    chk("rx status", b, 8'h40);
    repeat (64) begin
      host.xfer(8'h00, b);
      chk("rx byte", b, rxq.pop_front());
    end
    host.stop();
    chk("rx count", {1'b0, rxc}, 8'h00);
    $display("receive drain done");
    // long packet: demod streams 80 bytes, host drains n-1 at a time, or all once n covers the rest
    left = 80;
    fork
      repeat (80) begin
        repeat (100) tick();
        u = 8'($random(seed));
        rxq.push_back(u);
        dd = u;
        dv = 1'b1;
        tick();
        dv = 1'b0;
      end
      while (left > 0) begin
        n1 = -1;
        do begin
          n0 = n1;
          tick();
          n1 = int'(rxc);
        end while (n0 != n1);
        if (n1 >= left || n1 > 1) begin
          n0 = (n1 >= left) ? left : n1 - 1;
          host.start();
          host.xfer(8'h80, b);
          repeat (n0) begin
            host.xfer(8'h00, b);
            chk("rx stream byte", b, rxq.pop_front());
          end
          host.stop();
          left -= n0;
        end
      end
    join
    chk("rx count", {1'b0, rxc}, 8'h00);
    chk("overflow", {7'h00, ovf}, 8'h00);
    $display("receive stream done");
    psel = radio_fifo_pkg::PIN_SEL_TX;
    for (int a = 0; a < 2; a++) begin
      host.start();
      host.xfer(8'h3f, b);
      // first byte already waits in the modulator register, outside the count
      chk("tx status", b, 8'(31 * a));
      repeat (32) begin
        t = 8'($random(seed));
        txq.push_back(t);
        host.xfer(t, b);
      end
      host.stop();
    end
    chk("tx count", {1'b0, txc}, 8'h3f);
    for (int k = 63; k >= 0; k--) begin
      for (int w = 0; w < 8 && mv !== 1'b1; w++) tick();
      chk("mod byte", md, txq.pop_front());
      mr = 1'b1;
      wm = k[3:0];
      tick();
      mr = 1'b0;
      repeat (5) tick();
      // modulator register refills from the fifo, so the fifo holds one less
      c = (k > 0) ? k - 1 : 0;
      chk("tx count", {1'b0, txc}, 8'(c));
      chk("tx pin", {7'h00, pin}, {7'h00, c >= 61 - 4 * (k % 16)});
    end
    mr = 1'b1;
    tick();
    mr = 1'b0;
    repeat (2) tick();
    chk("underflow", {7'h00, udf}, 8'h01);
    psel = 6'h05;
    eclr = 1'b1;
    tick();
    eclr = 1'b0;
    repeat (2) tick();
    chk("underflow", {7'h00, udf}, 8'h00);
    chk("other pin", {7'h00, pin}, 8'h00);
    $display("transmit done");
    final_report();
  end
endmodule : tb
